// [hw/access_layer_regs.sv]
// access layer control and status registers of the single-wire debug port
// assumes the port instruction decoder issues one-cycle reg_wr/reg_rd strobes on clk_sys;
// system-domain status arrives asynchronously and is synchronised here
module access_layer_regs
    import access_layer_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // port enable request (fuse or high-voltage entry), pulse
    input  wire logic       port_enable,
    // register port from the instruction decoder
    input  wire logic [3:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // key decoder events, one-cycle pulses
    input  wire logic       key_user_row_ok,
    input  wire logic       key_nvm_prog_ok,
    input  wire logic       key_erase_ok,
    // system domain status, asynchronous levels
    input  wire logic       sys_reset_active,
    input  wire logic       sys_sleep_active,
    input  wire logic       nvm_prog_done,
    input  wire logic       erase_done,
    input  wire logic       nvm_prog_allowed,
    input  wire logic       user_row_allowed,
    input  wire logic       lock_bits_set,
    input  wire logic [2:0] crc_state,
    // controls out
    output logic            port_active,
    output logic            port_logic_reset,
    output logic            contention_detect_off,
    output logic [1:0]      port_clock_select,
    output logic            sys_reset_request,
    output logic            sys_clock_request,
    output logic            user_row_done,
    output logic            user_row_key_active,
    output logic            nvm_prog_flag,
    output logic            erase_key_active
);

    // ************************************************************
    // synchronise system domain status
    // ************************************************************
    localparam int SYNC_W = 10;

    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync_lvl;

    assign sync_raw = {crc_state, lock_bits_set, user_row_allowed, nvm_prog_allowed,
                       erase_done, nvm_prog_done, sys_sleep_active, sys_reset_active};

    status_sync #(
        .WIDTH(SYNC_W)
    ) u_status_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (sync_raw),
        .sync_out (sync_lvl)
    );

    logic       s_sys_reset;
    logic       s_sleep;
    logic       s_nvm_done;
    logic       s_erase_done;
    logic       s_nvm_ready;
    logic       s_row_ready;
    logic       s_locked;
    logic [2:0] s_crc;

    assign s_sys_reset  = sync_lvl[0];
    assign s_sleep      = sync_lvl[1];
    assign s_nvm_done   = sync_lvl[2];
    assign s_erase_done = sync_lvl[3];
    assign s_nvm_ready  = sync_lvl[4];
    assign s_row_ready  = sync_lvl[5];
    assign s_locked     = sync_lvl[6];

    // ************************************************************
    // crc word: taken only once two synchronised samples agree
    // ************************************************************
    logic [2:0] crc_prev_ff;
    logic [2:0] crc_ff;

    // bits of a one-hot change may land a cycle apart; never show the mix
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            crc_prev_ff <= CRC_OFF;
            crc_ff      <= CRC_OFF;
        end else begin
            crc_prev_ff <= sync_lvl[9:7];
            if (sync_lvl[9:7] == crc_prev_ff) begin
                crc_ff <= crc_prev_ff;
            end
        end
    end

    assign s_crc = crc_ff;

    // ************************************************************
    // write decode
    // ************************************************************
    logic wr_ctrl_b;
    logic wr_rst_req;
    logic wr_clk_ctrl;
    logic wr_sys_ctrl;
    logic rd_sys_status;
    logic disable_now;

    assign wr_ctrl_b     = reg_wr && (reg_addr == OFS_PHY_CTRL_B);
    assign wr_rst_req    = reg_wr && (reg_addr == OFS_SYS_RESET_REQ);
    assign wr_clk_ctrl   = reg_wr && (reg_addr == OFS_PORT_CLOCK_CTRL);
    assign wr_sys_ctrl   = reg_wr && (reg_addr == OFS_SYSTEM_CONTROL);
    assign rd_sys_status = reg_rd && (reg_addr == OFS_SYSTEM_STATUS);
    assign disable_now   = wr_ctrl_b && reg_wdata[BIT_PORT_DISABLE];

    // ************************************************************
    // port enable / disable
    // ************************************************************
    logic active_ff;

    // port stays off after reset until enabled; disable wins over enable
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            active_ff <= 1'b0;
        end else if (disable_now) begin
            active_ff <= 1'b0;
        end else if (port_enable) begin
            active_ff <= 1'b1;
        end
    end

    assign port_active      = active_ff;
    assign port_logic_reset = !active_ff;

    // ************************************************************
    // physical-layer configuration
    // ************************************************************
    logic ccdet_off_ff;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || disable_now || !active_ff) begin
            ccdet_off_ff <= 1'b0;
        end else if (wr_ctrl_b) begin
            ccdet_off_ff <= reg_wdata[BIT_CONTENTION_DETECT_OFF];
        end
    end

    assign contention_detect_off = ccdet_off_ff;

    // ************************************************************
    // keys
    // ************************************************************
    logic row_key_ff;
    logic nvm_key_ff;
    logic erase_key_ff;

    // key decode pulses set; completion clears the nvm and erase keys, the user row key stays; set wins in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n || disable_now || !active_ff) begin
            row_key_ff   <= 1'b0;
            nvm_key_ff   <= 1'b0;
            erase_key_ff <= 1'b0;
        end else begin
            if (key_user_row_ok) begin
                row_key_ff <= 1'b1;
            end
            if (key_nvm_prog_ok) begin
                nvm_key_ff <= 1'b1;
            end else if (s_nvm_done) begin
                nvm_key_ff <= 1'b0;
            end
            if (key_erase_ok) begin
                erase_key_ff <= 1'b1;
            end else if (s_erase_done) begin
                erase_key_ff <= 1'b0;
            end
        end
    end

    assign user_row_key_active = row_key_ff;
    assign nvm_prog_flag       = nvm_key_ff;
    assign erase_key_active    = erase_key_ff;

    // ************************************************************
    // system reset request
    // ************************************************************
    logic rst_req_ff;

    // held across port disable on purpose: only a port-domain reset or a write without the signature clears it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rst_req_ff <= 1'b0;
        end else if (wr_rst_req) begin
            rst_req_ff <= (reg_wdata == RESET_SIGNATURE);
        end
    end

    // system reset drives the system only; port logic is never reset by it
    assign sys_reset_request = rst_req_ff;

    // ************************************************************
    // port clock select
    // ************************************************************
    logic [1:0] clk_sel_ff;

    // reserved code 0 is stored as written; the clock generator treats it as undefined
    always_ff @(posedge clk_sys) begin
        if (!rst_n || disable_now || !active_ff) begin
            clk_sel_ff <= RST_PORT_CLOCK_SEL;
        end else if (wr_clk_ctrl) begin
            clk_sel_ff <= reg_wdata[1:0];
        end
    end

    assign port_clock_select = clk_sel_ff;

    // ************************************************************
    // system control: clock request and user row done
    // ************************************************************
    logic clk_req_ff;
    logic row_done_ff;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || disable_now) begin
            clk_req_ff <= 1'b0;
        end else if (port_enable) begin
            // any enable request outside a disable write raises it again, even on an active port
            clk_req_ff <= 1'b1;
        end else if (wr_sys_ctrl && active_ff) begin
            clk_req_ff <= reg_wdata[BIT_SYS_CLOCK_REQUEST];
        end
    end

    // done flag: one-cycle start pulse to the flash programmer, key-gated
    always_ff @(posedge clk_sys) begin
        if (!rst_n || disable_now || !active_ff) begin
            row_done_ff <= 1'b0;
        end else begin
            row_done_ff <= wr_sys_ctrl && row_key_ff && reg_wdata[BIT_USER_ROW_DONE];
        end
    end

    assign sys_clock_request = clk_req_ff;
    assign user_row_done     = row_done_ff;

    // ************************************************************
    // sticky system-reset status, clear on read
    // ************************************************************
    logic rst_seen_ff;

    // set wins over the read clear so a reset in the read cycle is kept
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rst_seen_ff <= 1'b0;
        end else if (s_sys_reset || rst_req_ff) begin
            rst_seen_ff <= 1'b1;
        end else if (rd_sys_status) begin
            rst_seen_ff <= 1'b0;
        end
    end

    // ************************************************************
    // read mux, registered
    // ************************************************************
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;

    always_comb begin
        nxt_rdata = 8'h00;
        unique case (reg_addr)
            OFS_PHY_CTRL_B: begin
                nxt_rdata[BIT_CONTENTION_DETECT_OFF] = ccdet_off_ff;
            end
            OFS_KEY_STATUS: begin
                nxt_rdata[BIT_USER_ROW_KEY_ACTIVE] = row_key_ff;
                nxt_rdata[BIT_NVM_PROG_FLAG]       = nvm_key_ff;
                nxt_rdata[BIT_ERASE_KEY_ACTIVE]    = erase_key_ff;
            end
            OFS_SYS_RESET_REQ: begin
                nxt_rdata[BIT_SYS_RESET_HELD] = rst_req_ff;
            end
            OFS_PORT_CLOCK_CTRL: begin
                nxt_rdata[1:0] = clk_sel_ff;
            end
            OFS_SYSTEM_CONTROL: begin
                nxt_rdata[BIT_SYS_CLOCK_REQUEST] = clk_req_ff;
            end
            OFS_SYSTEM_STATUS: begin
                nxt_rdata[BIT_SYS_IN_RESET]   = rst_seen_ff || s_sys_reset || rst_req_ff;
                nxt_rdata[BIT_SYS_SLEEPING]   = s_sleep;
                nxt_rdata[BIT_NVM_PROG_READY] = s_nvm_ready;
                nxt_rdata[BIT_USER_ROW_READY] = s_row_ready;
                nxt_rdata[BIT_DEVICE_LOCKED]  = s_locked;
            end
            OFS_CRC_SCAN_STATUS: begin
                nxt_rdata[2:0] = s_crc;
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    // taken on the read strobe only, so the byte stands until the next read
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule

// [hw/access_layer_pkg.sv]
// access layer register set: offsets, field positions, reset values, codes
// assumes an 8-bit internal register port driven by the debug port instruction decoder
package access_layer_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [3:0] OFS_PHY_CTRL_B      = 4'h3;
    localparam logic [3:0] OFS_KEY_STATUS      = 4'h7;
    localparam logic [3:0] OFS_SYS_RESET_REQ   = 4'h8;
    localparam logic [3:0] OFS_PORT_CLOCK_CTRL = 4'h9;
    localparam logic [3:0] OFS_SYSTEM_CONTROL  = 4'ha;
    localparam logic [3:0] OFS_SYSTEM_STATUS   = 4'hb;
    localparam logic [3:0] OFS_CRC_SCAN_STATUS = 4'hc;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_CONTENTION_DETECT_OFF = 3;
    localparam int BIT_PORT_DISABLE          = 2;
    localparam int BIT_USER_ROW_KEY_ACTIVE   = 5;
    localparam int BIT_NVM_PROG_FLAG         = 4;
    localparam int BIT_ERASE_KEY_ACTIVE      = 3;
    localparam int BIT_SYS_RESET_HELD        = 0;
    localparam int BIT_USER_ROW_DONE         = 1;
    localparam int BIT_SYS_CLOCK_REQUEST     = 0;
    localparam int BIT_SYS_IN_RESET          = 5;
    localparam int BIT_SYS_SLEEPING          = 4;
    localparam int BIT_NVM_PROG_READY        = 3;
    localparam int BIT_USER_ROW_READY        = 2;
    localparam int BIT_DEVICE_LOCKED         = 0;

    // ************************************************************
    // values and reset values
    // ************************************************************
    localparam logic [7:0] RESET_SIGNATURE     = 8'h59;
    localparam logic [1:0] RST_PORT_CLOCK_SEL  = 2'h3;

    typedef enum logic [1:0] {
        CLK_RESERVED = 2'h0,
        CLK_16MHZ    = 2'h1,
        CLK_8MHZ     = 2'h2,
        CLK_4MHZ     = 2'h3
    } port_clock_sel_e;

    localparam logic [2:0] CRC_OFF  = 3'h0;
    localparam logic [2:0] CRC_BUSY = 3'h1;
    localparam logic [2:0] CRC_OK   = 3'h2;
    localparam logic [2:0] CRC_FAIL = 3'h4;

endpackage

// [hw/status_sync.sv]
// two-flop synchroniser bank for status levels from the system domain
// assumes inputs are quasi-static levels from other clock domains
module status_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage is read only by the second stage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// [tb/access_layer_checker.sv]
// checker: timing relations at the access layer register ports
// assumes it is bound onto access_layer_regs, one clock domain
module access_layer_checker
    import access_layer_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       port_enable,
    input wire logic [3:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       key_erase_ok,
    input wire logic       port_active,
    input wire logic       port_logic_reset,
    input wire logic       contention_detect_off,
    input wire logic [1:0] port_clock_select,
    input wire logic       sys_reset_request,
    input wire logic       sys_clock_request,
    input wire logic       user_row_done,
    input wire logic       user_row_key_active,
    input wire logic       nvm_prog_flag,
    input wire logic       erase_key_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // helper state: last write data, key and request levels
    // ****************************************
    logic [7:0] wd_ff;
    logic [7:0] keys_ff;
    logic       req_ff;
    logic       dis_ff;
    always_ff @(posedge clk_sys) begin
        dis_ff  <= reg_wr && reg_addr == OFS_PHY_CTRL_B && reg_wdata[BIT_PORT_DISABLE];
        wd_ff   <= reg_wdata;
        keys_ff <= {2'h0, user_row_key_active, nvm_prog_flag, erase_key_active, 3'h0};
        req_ff  <= sys_reset_request;
    end

    sequence wr_to(logic [3:0] a);
        reg_wr && reg_addr == a;
    endsequence
    sequence rd_of(logic [3:0] a);
        reg_rd && reg_addr == a;
    endsequence
    // the done strobe is one cycle wide, never a level
    sequence done_pulse;
        user_row_done ##1 !user_row_done;
    endsequence

    // ****************************************
    // assertions
    // ****************************************
    reset_hold_a: assert property (wr_to(OFS_SYS_RESET_REQ) |=>
        sys_reset_request == (wd_ff == RESET_SIGNATURE)) else $error("reset request level wrong");
    reset_read_a: assert property (rd_of(OFS_SYS_RESET_REQ) |=>
        reg_rdata == {7'h0, req_ff}) else $error("reset request readback wrong");
    key_read_a: assert property (rd_of(OFS_KEY_STATUS) |=>
        reg_rdata == keys_ff) else $error("key status readback wrong");
    clock_sel_a: assert property (wr_to(OFS_PORT_CLOCK_CTRL) && port_active |=>
        port_clock_select == wd_ff[1:0]) else $error("clock select not stored");
    port_off_a: assert property (wr_to(OFS_PHY_CTRL_B) && reg_wdata[BIT_PORT_DISABLE] |=>
        !port_active && !sys_clock_request && !user_row_key_active && !nvm_prog_flag
        && !erase_key_active && !contention_detect_off && port_clock_select == RST_PORT_CLOCK_SEL)
        else $error("port disable left state behind");
    port_on_a: assert property ($rose(port_enable) |=>
        port_active && sys_clock_request) else $error("enable did not request clock");
    logic_reset_a: assert property (port_logic_reset != port_active)
        else $error("port logic reset disagrees with port state");
    row_done_a: assert property (wr_to(OFS_SYSTEM_CONTROL) && reg_wdata[BIT_USER_ROW_DONE]
        && user_row_key_active |=> done_pulse) else $error("user row done pulse missing");
    row_refuse_a: assert property (wr_to(OFS_SYSTEM_CONTROL) && !user_row_key_active
        |=> !user_row_done) else $error("user row done without key");
    clock_req_a: assert property (wr_to(OFS_SYSTEM_CONTROL) && port_active |=>
        sys_clock_request == wd_ff[BIT_SYS_CLOCK_REQUEST]) else $error("clock request not stored");
    unused_read_a: assert property (reg_rd && (reg_addr inside {[4'h0:4'h2], [4'h4:4'h6],
        [4'hd:4'hf]}) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    erase_key_a: assert property (key_erase_ok && port_active |=>
        erase_key_active) else $error("erase key not taken");
    off_cause_a: assert property ($fell(port_active) |-> dis_ff)
        else $error("port went inactive without a disable write");
endmodule

bind access_layer_regs access_layer_checker i_chk (.clk_sys, .rst_n, .port_enable, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .key_erase_ok, .port_active, .port_logic_reset,
    .contention_detect_off, .port_clock_select, .sys_reset_request, .sys_clock_request,
    .user_row_done, .user_row_key_active, .nvm_prog_flag, .erase_key_active);

// [tb/programmer_model.sv]
// programmer side model: register writes and reads, one byte at a time
// assumes strobes are taken on the rising clk_sys edge, read data one cycle later
module programmer_model (
    input  wire logic       clk_sys,
    output logic      [3:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr  = 4'h0;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end
    // released lines show the inverse of the last value, never a held copy
    // callers send the done bit both before and after the row key, reset both before and after programming
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk_sys);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask
endmodule

// [tb/test_access_layer_regs.sv]
// self-checking bench for the access layer register set
// assumes the programmer model drives the register port; system side is driven here
module test_access_layer_regs
    import access_layer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       port_enable = 1'b0;
    logic       key_user_row_ok = 1'b0;
    logic       key_nvm_prog_ok = 1'b0;
    logic       key_erase_ok = 1'b0;
    logic [6:0] sysv = 7'h01;
    logic [2:0] crc_state = 3'h0;
    logic [3:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] rd_v;
    logic [7:0] v;
    logic [1:0] port_clock_select;
    logic       port_active, port_logic_reset, contention_detect_off, sys_reset_request;
    logic       sys_clock_request, user_row_done, user_row_key_active, nvm_prog_flag;
    logic       erase_key_active;
    int         failures = 0;
    int         checks_done = 0;
    int         seed = 34;
    int         sticky = 0;

    always #4 clk_sys = ~clk_sys;

    programmer_model i_prog (.clk_sys, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
    access_layer_regs i_dut (.clk_sys, .rst_n, .port_enable, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .key_user_row_ok, .key_nvm_prog_ok, .key_erase_ok,
        .sys_reset_active(sysv[6]), .sys_sleep_active(sysv[5]), .nvm_prog_allowed(sysv[4]),
        .user_row_allowed(sysv[3]), .nvm_prog_done(sysv[2]), .erase_done(sysv[1]),
        .lock_bits_set(sysv[0]), .crc_state, .port_active, .port_logic_reset,
        .contention_detect_off, .port_clock_select, .sys_reset_request, .sys_clock_request,
        .user_row_done, .user_row_key_active, .nvm_prog_flag, .erase_key_active);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        i_prog.rd(a, rd_v);
        chk(rd_v, exp);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    // status inputs pass a two-flop synchroniser, so settle before reading
    task automatic settle();
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic complete_run();
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        complete_run();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int a = 0; a < 16; a++) begin
            v = (a == 11) ? 8'h01 : (a == 9) ? 8'h03 : 8'h00;
            rchk(a[3:0], v);
        end
        i_prog.wr(OFS_SYSTEM_CONTROL, 8'h03);
        chk({7'h0, user_row_done}, 8'h00);
        pulse(port_enable);
        chk({7'h0, sys_clock_request}, 8'h01);
        for (int c = 0; c < 4; c++) begin
            v = (xs() & 8'hfc) | 8'(c);
            i_prog.wr(OFS_PORT_CLOCK_CTRL, v);
            chk({6'h0, port_clock_select}, 8'(c));
            rchk(OFS_PORT_CLOCK_CTRL, 8'(c));
        end
        i_prog.wr(OFS_SYSTEM_CONTROL, 8'h00);
        rchk(OFS_SYSTEM_CONTROL, 8'h00);
        i_prog.wr(OFS_SYSTEM_CONTROL, 8'h01);
        rchk(OFS_SYSTEM_CONTROL, 8'h01);
        i_prog.wr(OFS_PHY_CTRL_B, 8'h08);
        chk({7'h0, contention_detect_off}, 8'h01);
        i_prog.wr(OFS_SYS_RESET_REQ, RESET_SIGNATURE);
        rchk(OFS_SYS_RESET_REQ, 8'h01);
        chk({7'h0, port_active}, 8'h01);
        v = xs();
        if (v == RESET_SIGNATURE) v = 8'h00;
        i_prog.wr(OFS_SYS_RESET_REQ, v);
        rchk(OFS_SYS_RESET_REQ, 8'h00);
        pulse(key_user_row_ok);
        pulse(key_nvm_prog_ok);
        pulse(key_erase_ok);
        rchk(OFS_KEY_STATUS, 8'h38);
        chk({5'h0, user_row_key_active, nvm_prog_flag, erase_key_active}, 8'h07);
        i_prog.wr(OFS_SYSTEM_CONTROL, 8'h03);
        chk({7'h0, user_row_done}, 8'h01);
        sysv[2] = 1'b1;
        settle();
        rchk(OFS_KEY_STATUS, 8'h28);
        i_prog.wr(OFS_SYS_RESET_REQ, RESET_SIGNATURE);
        chk({7'h0, sys_reset_request}, 8'h01);
        i_prog.wr(OFS_SYS_RESET_REQ, 8'h00);
        chk({7'h0, sys_reset_request}, 8'h00);
        sysv[1] = 1'b1;
        settle();
        rchk(OFS_KEY_STATUS, 8'h20);
        sysv[6] = 1'b1;
        settle();
        sysv = 7'h01;
        sticky = 1;
        settle();
        for (int i = 0; i < 6; i++) begin
            rchk(OFS_SYSTEM_STATUS, {2'h0, sysv[6] | sticky[0], sysv[5:3], 1'b0, sysv[0]});
            sticky = int'(sysv[6]);
            sysv = 7'(xs()) & 7'h79;
            settle();
        end
        for (int i = 0; i < 8; i++) begin
            crc_state = (i < 4) ? (3'h1 << i) & 3'h7 : 3'h0;
            settle();
            rchk(OFS_CRC_SCAN_STATUS, {5'h0, crc_state});
        end
        i_prog.wr(OFS_PORT_CLOCK_CTRL, 8'h01);
        i_prog.wr(OFS_PHY_CTRL_B, 8'h04);
        chk({6'h0, port_logic_reset, port_active}, 8'h02);
        rchk(OFS_KEY_STATUS, 8'h00);
        rchk(OFS_PORT_CLOCK_CTRL, 8'h03);
        rchk(OFS_SYSTEM_CONTROL, 8'h00);
        rchk(OFS_PHY_CTRL_B, 8'h00);
        pulse(port_enable);
        chk({6'h0, port_clock_select}, 8'h03);
        rchk(OFS_SYSTEM_CONTROL, 8'h01);
        complete_run();
    end
endmodule
